// [verilog/scalar_shift_add_units.sv]
// Scalar double shift, integer add and floating add units behind one issue port.
//
// Behaviour
// - Left double shift: dest over first source, shift left, keep upper word.
// - Right double shift: first source over dest, shift right, keep lower word.
// - Count field zero gives shift count one, never address register zero.
// - First-source field zero concatenates the destination with a zero word.
// - Shift count above 127 clears the destination.
// - Equal nonzero dest and source fields, count up to 64, rotates.
// - Only the destination is written; the first source stays unchanged.
// - Integer add writes the 64-bit sum of both sources.
// - Integer add with first field zero copies the second source.
// - Integer add with both fields zero writes the sign bit only.
// - Integer subtract writes first source minus second source.
// - Integer subtract with both fields zero writes the top bit only.
// - Integer subtract with first field zero writes the negated second source.
// - Floating add writes a normalized sum, whatever the operands.
// - Floating add with first field zero normalizes the second source.
// - Floating subtract writes a normalized first minus second.
// - Floating subtract with first field zero writes the normalized negation.
// - Opcodes are routed to the shift, integer or floating unit.
`timescale 1ns/1ps
`default_nettype none
module scalar_shift_add_units
   import scalar_units_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic issue_valid,
   input wire logic [15:0] issue_parcel,
   input wire logic [63:0] dest_scalar_reg,
   input wire logic [63:0] first_src_scalar_reg,
   input wire logic [63:0] second_src_scalar_reg,
   input wire logic [23:0] shift_count_addr_reg,
   output logic issue_ready,
   output logic result_valid,
   output logic [2:0] result_dest,
   output logic [63:0] result_data,
   output logic [3:0] result_unit,
   output logic issue_reject
);

   ////////////////////////////////////////////////////////////////////////////
   // Parcel decode.

   logic [6:0] opcode;
   logic [2:0] fld_dst;
   logic [2:0] fld_src1;
   logic [2:0] fld_src2;
   logic src1_zero;
   logic src2_zero;

   // The issue side presents register contents already selected by these fields.
   // designator extraction
   assign opcode = issue_parcel[OP_LSB +: OP_W];
   assign fld_dst = issue_parcel[DST_LSB +: FLD_W];
   assign fld_src1 = issue_parcel[SRC1_LSB +: FLD_W];
   assign fld_src2 = issue_parcel[SRC2_LSB +: FLD_W];
   assign src1_zero = (fld_src1 == FLD_ZERO);
   assign src2_zero = (fld_src2 == FLD_ZERO);

   ////////////////////////////////////////////////////////////////////////////
   // Unit routing.

   unit_sel_e unit_sel;
   logic is_shift;
   logic is_iadd;
   logic is_fadd;
   logic is_sub;

   assign is_shift = (opcode == OP_DSHL) || (opcode == OP_DSHR);
   assign is_iadd = (opcode == OP_IADD) || (opcode == OP_ISUB);
   assign is_fadd = (opcode == OP_FADD) || (opcode == OP_FSUB);
   assign is_sub = (opcode == OP_ISUB) || (opcode == OP_FSUB);
   assign unit_sel = is_shift ? UNIT_SHIFT :
                     is_iadd ? UNIT_IADD :
                     is_fadd ? UNIT_FADD : UNIT_NONE;

   // Every unit completes in one cycle, so issue is never stalled.
   assign issue_ready = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Operand selection for zero designators.

   logic [63:0] src1_word;
   logic [63:0] int_src2_word;
   logic [63:0] fp_src2_word;
   logic [23:0] shift_count;

   // zero first field reads a zero word
   assign src1_word = src1_zero ? WORD_ZERO : first_src_scalar_reg;
   // A zero second field reads as the sign bit alone at the integer unit, which gives both
   // the sign-only sum and the sign-only difference with a zero first field.
   // sign-only operand for zero field
   assign int_src2_word = src2_zero ? SIGN_ONLY : second_src_scalar_reg;
   assign fp_src2_word = src2_zero ? WORD_ZERO : second_src_scalar_reg;
   // zero count field gives count one
   assign shift_count = src2_zero ? COUNT_ONE : shift_count_addr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Functional units.

   logic [63:0] shift_out;
   logic [63:0] int_out;
   logic [63:0] fp_out;

   double_shift_unit u_shift (
      .shift_right(opcode == OP_DSHR),
      .dest_word(dest_scalar_reg),
      .src_word(src1_word),
      .count(shift_count),
      .shift_result(shift_out)
   );

   // Zero first field makes the sum a copy and the difference a negation.
   // integer sum
   assign int_out = is_sub ? (src1_word - int_src2_word) : (src1_word + int_src2_word);

   fp_add_unit u_fadd (
      .subtract(is_sub),
      .op_a(src1_word),
      .op_b(fp_src2_word),
      .fp_result(fp_out)
   );

   logic [63:0] unit_out;

   // The one-hot select keeps this a flat AND-OR mux.
   assign unit_out = ({64{unit_sel == UNIT_SHIFT}} & shift_out) |
                     ({64{unit_sel == UNIT_IADD}} & int_out) |
                     ({64{unit_sel == UNIT_FADD}} & fp_out);

   ////////////////////////////////////////////////////////////////////////////
   // Result registers.

   logic result_valid_r, result_valid_nxt;
   logic reject_r, reject_nxt;
   logic [2:0] result_dest_r;
   logic [63:0] result_data_r;
   logic [3:0] result_unit_r;
   logic take;

   assign take = issue_valid && (unit_sel != UNIT_NONE);
   assign result_valid_nxt = take;
   assign reject_nxt = issue_valid && (unit_sel == UNIT_NONE);

   // Handshake flags follow every issue cycle.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         result_valid_r <= 1'b0;
         reject_r <= 1'b0;
      end else begin
         result_valid_r <= result_valid_nxt;
         reject_r <= reject_nxt;
      end
   end

   // Data hold their last value between results to save toggling.
   // single destination write
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         result_dest_r <= FLD_ZERO;
         result_data_r <= WORD_ZERO;
         result_unit_r <= UNIT_NONE;
      end else if (take) begin
         result_dest_r <= fld_dst;
         result_data_r <= unit_out;
         result_unit_r <= unit_sel;
      end
   end

   assign result_valid = result_valid_r;
   assign issue_reject = reject_r;
   assign result_dest = result_dest_r;
   assign result_data = result_data_r;
   assign result_unit = result_unit_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb_sys @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   logic issue_l, issue_r, issue_a, issue_s, issue_f, issue_fs;
   int rot_n;

   assign issue_l = issue_valid && (opcode == OP_DSHL);
   assign issue_r = issue_valid && (opcode == OP_DSHR);
   assign issue_a = issue_valid && (opcode == OP_IADD);
   assign issue_s = issue_valid && (opcode == OP_ISUB);
   assign issue_f = issue_valid && (opcode == OP_FADD);
   assign issue_fs = issue_valid && (opcode == OP_FSUB);
   assign rot_n = int'(shift_count_addr_reg[6:0]);

   logic [127:0] pair_l;
   logic [127:0] pair_r;
   logic [63:0] left_ref;
   logic [63:0] right_ref;

   // Reference shifts built from the raw pair, independent of the operand muxes.
   assign pair_l = {dest_scalar_reg, first_src_scalar_reg} << rot_n;
   assign pair_r = {first_src_scalar_reg, dest_scalar_reg} >> rot_n;
   assign left_ref = pair_l[127:64];
   assign right_ref = pair_r[63:0];

   a_shift_clear_big: assert property (
      (issue_l || issue_r) && !src2_zero && (shift_count_addr_reg > COUNT_MAX)
      |=> result_valid && (result_data == WORD_ZERO))
      else $error("double shift with large count did not clear");

   a_shift_count_one: assert property (
      issue_l && src2_zero && src1_zero
      |=> result_data == ($past(dest_scalar_reg) << 1))
      else $error("zero count field did not shift by one");

   a_shift_rotate_left: assert property (
      issue_l && !src2_zero && (fld_dst == fld_src1) && !src1_zero &&
      (shift_count_addr_reg <= 24'h000040) && (dest_scalar_reg == first_src_scalar_reg)
      |=> result_data == (($past(dest_scalar_reg) << $past(rot_n)) |
                          ($past(dest_scalar_reg) >> (64 - $past(rot_n)))))
      else $error("left double shift is not a rotation");

   a_shift_right_zero: assert property (
      issue_r && src1_zero && !src2_zero && (shift_count_addr_reg <= COUNT_MAX)
      |=> result_data == ($past(dest_scalar_reg) >> $past(rot_n)))
      else $error("right shift with zero source word is wrong");

   a_iadd_sum: assert property (
      issue_a && !src1_zero && !src2_zero
      |=> result_data == 64'($past(first_src_scalar_reg) + $past(second_src_scalar_reg)))
      else $error("integer sum is wrong");

   a_iadd_copy: assert property (
      issue_a && src1_zero && !src2_zero
      |=> result_data == $past(second_src_scalar_reg))
      else $error("integer add did not copy second source");

   a_iadd_sign_only: assert property (
      (issue_a || issue_s) && src1_zero && src2_zero
      |=> result_valid && (result_data == SIGN_ONLY))
      else $error("both-zero integer result is not the sign bit");

   a_isub_diff: assert property (
      issue_s && !src1_zero && !src2_zero
      |=> result_data == 64'($past(first_src_scalar_reg) - $past(second_src_scalar_reg)))
      else $error("integer difference is wrong");

   a_isub_negate: assert property (
      issue_s && src1_zero && !src2_zero
      |=> result_data == 64'(WORD_ZERO - $past(second_src_scalar_reg)))
      else $error("integer negation is wrong");

   a_fadd_normal: assert property (
      issue_f || issue_fs
      |=> (result_data == WORD_ZERO) || result_data[COEF_W-1])
      else $error("floating result is not normalized");

   a_fsub_negate_sign: assert property (
      issue_fs && src1_zero && !src2_zero && (second_src_scalar_reg[47:0] != 48'h0)
      |=> result_data[SIGN_BIT] == !$past(second_src_scalar_reg[SIGN_BIT]))
      else $error("floating negation kept the sign");

   a_route_unit: assert property (
      issue_valid |=> (result_valid && (result_unit == $past(unit_sel)) &&
                      (result_dest == $past(fld_dst))) ^ issue_reject)
      else $error("instruction routed to the wrong unit");

   a_shift_left_full: assert property (
      issue_l && !src1_zero && !src2_zero && (shift_count_addr_reg <= COUNT_MAX)
      |=> result_data == $past(left_ref))
      else $error("left double shift lost bits of the pair");

   a_shift_right_full: assert property (
      issue_r && !src1_zero && !src2_zero && (shift_count_addr_reg <= COUNT_MAX)
      |=> result_data == $past(right_ref))
      else $error("right double shift lost bits of the pair");

   a_shift_left_zero: assert property (
      issue_l && src1_zero && !src2_zero && (shift_count_addr_reg <= COUNT_MAX)
      |=> result_data == ($past(dest_scalar_reg) << $past(rot_n)))
      else $error("left shift with zero source word is wrong");

   a_shift_count_right: assert property (
      issue_r && src2_zero && src1_zero
      |=> result_data == ($past(dest_scalar_reg) >> 1))
      else $error("zero count field did not shift right by one");

   a_shift_rotate_right: assert property (
      issue_r && !src2_zero && (fld_dst == fld_src1) && !src1_zero &&
      (shift_count_addr_reg <= 24'h000040) && (dest_scalar_reg == first_src_scalar_reg)
      |=> result_data == (($past(dest_scalar_reg) >> $past(rot_n)) |
                          ($past(dest_scalar_reg) << (64 - $past(rot_n)))))
      else $error("right double shift is not a rotation");

   a_isub_top_bit: assert property (
      issue_s && src1_zero && src2_zero
      |=> result_valid && (result_data == SIGN_ONLY))
      else $error("both-zero difference is not the top bit");

   a_fadd_copy_norm: assert property (
      issue_f && src1_zero && !src2_zero && second_src_scalar_reg[COEF_W-1]
      |=> result_data == $past(second_src_scalar_reg))
      else $error("normalized second source was altered");

   a_fsub_self_zero: assert property (
      issue_fs && !src1_zero && !src2_zero && (first_src_scalar_reg == second_src_scalar_reg)
      |=> result_data == WORD_ZERO)
      else $error("difference of equal words is not zero");

   a_route_shift: assert property (
      issue_l || issue_r |=> result_unit == UNIT_SHIFT)
      else $error("double shift not sent to the shift unit");

   a_route_int: assert property (
      issue_a || issue_s |=> result_unit == UNIT_IADD)
      else $error("integer form not sent to the integer unit");

   a_route_float: assert property (
      issue_f || issue_fs |=> result_unit == UNIT_FADD)
      else $error("floating form not sent to the floating unit");

   a_reject_range: assert property (
      issue_valid && ((opcode < OP_DSHL) || (opcode > OP_FSUB))
      |=> issue_reject && !result_valid)
      else $error("opcode outside the handled range was not refused");

   a_result_hold: assert property (
      !issue_valid |=> !result_valid && $stable(result_data) && $stable(result_dest))
      else $error("result changed without an issue");

   c_shift_clear: cover property ((issue_l || issue_r) && (shift_count_addr_reg > COUNT_MAX));
   c_rotate: cover property (issue_r && (fld_dst == fld_src1) && !src1_zero);
   c_iadd_both_zero: cover property (issue_a && src1_zero && src2_zero);
   c_fsub: cover property (issue_fs ##1 result_valid);
   c_reject: cover property (issue_valid && (unit_sel == UNIT_NONE));
endmodule
`default_nettype wire

// [verilog/scalar_units_pkg.sv]
// Shared constants for the scalar shift, integer add and floating add units.
package scalar_units_pkg;
   localparam int WORD_W = 64;
   localparam int CNT_W = 24;
   localparam int FLD_W = 3;
   localparam int OP_W = 7;
   localparam int PARCEL_W = 16;
   // Parcel field positions: opcode, destination, first source, second source/count.
   localparam int OP_LSB = 9;
   localparam int DST_LSB = 6;
   localparam int SRC1_LSB = 3;
   localparam int SRC2_LSB = 0;
   // Opcodes handled here.
   localparam logic [6:0] OP_DSHL = 7'h2E;
   localparam logic [6:0] OP_DSHR = 7'h2F;
   localparam logic [6:0] OP_IADD = 7'h30;
   localparam logic [6:0] OP_ISUB = 7'h31;
   localparam logic [6:0] OP_FADD = 7'h32;
   localparam logic [6:0] OP_FSUB = 7'h33;
   // Floating word layout: sign, biased exponent, coefficient.
   localparam int SIGN_BIT = 63;
   localparam int EXP_W = 15;
   localparam int COEF_W = 48;
   localparam int EXP_LSB = 48;
   localparam logic [2:0] FLD_ZERO = 3'h0;
   localparam logic [63:0] WORD_ZERO = 64'h0000_0000_0000_0000;
   localparam logic [63:0] SIGN_ONLY = 64'h8000_0000_0000_0000;
   localparam logic [23:0] COUNT_ONE = 24'h000001;
   localparam logic [23:0] COUNT_MAX = 24'h00007F;
   localparam int SHAMT_W = 7;
   typedef enum logic [3:0] {
      UNIT_NONE = 4'b0001,
      UNIT_SHIFT = 4'b0010,
      UNIT_IADD = 4'b0100,
      UNIT_FADD = 4'b1000
   } unit_sel_e;
endpackage

// [verilog/double_shift_unit.sv]
// Double-word shift datapath for the left and right concatenated shifts.
`timescale 1ns/1ps
`default_nettype none
module double_shift_unit
   import scalar_units_pkg::*;
(
   input wire logic shift_right,
   input wire logic [63:0] dest_word,
   input wire logic [63:0] src_word,
   input wire logic [23:0] count,
   output logic [63:0] shift_result
);
   logic [127:0] cat_left;
   logic [127:0] cat_right;
   logic [127:0] moved_left;
   logic [127:0] moved_right;
   logic [6:0] shamt;
   logic too_far;

   // Only the low seven count bits steer the shifter; wider counts clear below.
   // low seven bits
   assign shamt = count[SHAMT_W-1:0];
   assign cat_left = {dest_word, src_word};
   assign cat_right = {src_word, dest_word};
   assign moved_left = cat_left << shamt;
   assign moved_right = cat_right >> shamt;
   assign too_far = count > COUNT_MAX;
   // Equal source and destination words make these shifts rotate for counts up to 64.
   // rotation via concatenation
   assign shift_result = too_far ? WORD_ZERO :
                         (shift_right ? moved_right[63:0] : moved_left[127:64]);
endmodule
`default_nettype wire

// [verilog/fp_add_unit.sv]
// Floating add/subtract datapath with forced normalization of the result.
`timescale 1ns/1ps
`default_nettype none
module fp_add_unit
   import scalar_units_pkg::*;
(
   input wire logic subtract,
   input wire logic [63:0] op_a,
   input wire logic [63:0] op_b,
   output logic [63:0] fp_result
);
   // Leading zero count of a coefficient.
   function automatic logic [5:0] lead_zeros(input logic [47:0] v);
      logic [5:0] n;
      logic seen;
      n = 6'h00;
      seen = 1'b0;
      for (int i = COEF_W - 1; i >= 0; i--) begin
         if (!seen && !v[i]) begin
            n = n + 6'h01;
         end else begin
            seen = 1'b1;
         end
      end
      return n;
   endfunction

   logic sa, sb;
   logic [14:0] ea, eb;
   logic [47:0] ca, cb;
   logic a_big;
   logic s_big, s_small;
   logic [14:0] e_big, e_diff;
   logic [47:0] c_big, c_small, c_align;
   logic [49:0] mag_raw, mag;
   logic res_sign, mag_neg;
   logic [5:0] lz;
   logic [47:0] c_norm;
   logic [14:0] e_norm;

   assign sa = op_a[SIGN_BIT];
   assign ea = op_a[EXP_LSB +: EXP_W];
   assign ca = op_a[COEF_W-1:0];
   assign sb = op_b[SIGN_BIT] ^ subtract;
   assign eb = op_b[EXP_LSB +: EXP_W];
   assign cb = op_b[COEF_W-1:0];
   // A zero coefficient wins alignment only against another zero, so its exponent is ignored.
   assign a_big = (cb == 48'h0) || ((ca != 48'h0) && (ea >= eb));
   assign s_big = a_big ? sa : sb;
   assign s_small = a_big ? sb : sa;
   assign e_big = a_big ? ea : eb;
   assign c_big = a_big ? ca : cb;
   assign c_small = a_big ? cb : ca;
   assign e_diff = a_big ? (ea - eb) : (eb - ea);
   assign c_align = (e_diff >= 15'(COEF_W)) ? 48'h0 : (c_small >> e_diff);
   assign mag_raw = (s_big == s_small) ? ({2'b00, c_big} + {2'b00, c_align}) :
                    ({2'b00, c_big} - {2'b00, c_align});
   assign mag_neg = mag_raw[49];
   assign mag = mag_neg ? (50'h0 - mag_raw) : mag_raw;
   assign res_sign = s_big ^ mag_neg;
   assign lz = lead_zeros(mag[47:0]);
   // shift coefficient up to top bit
   assign c_norm = mag[48] ? mag[48:1] : (mag[47:0] << lz);
   assign e_norm = mag[48] ? (e_big + 15'h0001) : (e_big - 15'(lz));
   // Exponent underflow during normalization yields a clean zero; overflow wraps.
   assign fp_result = ((mag == 50'h0) || (!mag[48] && (e_big < 15'(lz)))) ? WORD_ZERO :
                      {res_sign, e_norm, c_norm};
endmodule
`default_nettype wire

// [dv/scalar_file_model.sv]
// Partner model: scalar and address register files read by the issue logic.
`timescale 1ns/1ps
`default_nettype none
module scalar_file_model
   import scalar_units_pkg::*;
(
   input wire logic issue_valid,
   input wire logic [15:0] issue_parcel,
   output logic [63:0] dest_word,
   output logic [63:0] src1_word,
   output logic [63:0] src2_word,
   output logic [23:0] count_word
);
   logic [63:0] s_file [8];
   logic [23:0] a_file [8];
   logic [2:0] i_fld;
   logic [2:0] j_fld;
   logic [2:0] k_fld;
   ////////////////////////////////////////////////////////////////////////////////
   // Register zero holds junk so that any read of it instead of zero shows up.
   initial begin
      s_file = '{64'hDEAD_BEEF_0BAD_F00D, 64'h0123_4567_89AB_CDEF, 64'hF0E1_D2C3_B4A5_9687,
                 64'h4001_8000_0000_0000, 64'h4002_C000_0000_0000, 64'h4005_0000_1000_0000,
                 64'h7FFF_FFFF_FFFF_FFFF, 64'h0000_0000_0000_0001};
      a_file = '{24'h000009, 24'h000005, 24'h000040, 24'h00007F, 24'h000080, 24'h000100,
                 24'h000003, 24'h000041};
   end
   ////////////////////////////////////////////////////////////////////////////////
   // parcel field decode.
   assign i_fld = issue_parcel[8:6];
   assign j_fld = issue_parcel[5:3];
   assign k_fld = issue_parcel[2:0];
   // Outside an issue the read ports show inverted words, not stale ones.
   assign dest_word = issue_valid ? s_file[i_fld] : ~s_file[i_fld];
   assign src1_word = issue_valid ? s_file[j_fld] : ~s_file[j_fld];
   assign src2_word = issue_valid ? s_file[k_fld] : ~s_file[k_fld];
   assign count_word = issue_valid ? a_file[k_fld] : ~a_file[k_fld];
endmodule
`default_nettype wire

// [dv/scalar_shift_add_units_bench.sv]
// Self-checking bench for the scalar shift, integer add and floating add units.
`timescale 1ns/1ps
`default_nettype none
module scalar_shift_add_units_bench;
   import scalar_units_pkg::*;
   logic clk_sys;
   logic sys_rst;
   logic issue_valid;
   logic [15:0] issue_parcel;
   logic [63:0] dest_w;
   logic [63:0] src1_w;
   logic [63:0] src2_w;
   logic [23:0] count_w;
   logic issue_ready;
   logic result_valid;
   logic [2:0] result_dest;
   logic [63:0] result_data;
   logic [3:0] result_unit;
   logic issue_reject;
   int fail_count;
   int cmp_count;
   ////////////////////////////////////////////////////////////////////////////////
   scalar_file_model scalar_file_model_inst (.issue_valid(issue_valid),
      .issue_parcel(issue_parcel), .dest_word(dest_w), .src1_word(src1_w),
      .src2_word(src2_w), .count_word(count_w));
   scalar_shift_add_units scalar_shift_add_units_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .issue_valid(issue_valid), .issue_parcel(issue_parcel), .dest_scalar_reg(dest_w),
      .first_src_scalar_reg(src1_w), .second_src_scalar_reg(src2_w),
      .shift_count_addr_reg(count_w), .issue_ready(issue_ready), .result_valid(result_valid),
      .result_dest(result_dest), .result_data(result_data), .result_unit(result_unit),
      .issue_reject(issue_reject));
   // The clock toggles every 20 ns, a period of 40 ns.
   always #20 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [63:0] sreg(input int n);
      return scalar_file_model_inst.s_file[n];
   endfunction
   // Reference double shift worked out from the concatenation rules.
   function automatic logic [63:0] dshift(input logic rt, input logic [63:0] si,
                                          input logic [63:0] sj, input logic [23:0] n);
      logic [127:0] v;
      if (n > 24'h00007F) return 64'h0000_0000_0000_0000;
      if (rt) begin
         v = {sj, si} >> n[6:0];
         return v[63:0];
      end
      v = {si, sj} << n[6:0];
      return v[127:64];
   endfunction
   // Operands sampled at one edge; the registered answer is judged in the next cycle.
   // Leaving the valid high lets consecutive calls issue back to back.
   task automatic run(input logic [15:0] p, input logic [63:0] exp, input unit_sel_e u);
      issue_valid = 1'b1;
      issue_parcel = p;
      @(posedge clk_sys);
      @(negedge clk_sys);
      check(64'(result_valid), 64'h1);
      check(64'(issue_reject), 64'h0);
      check(result_data, exp);
      check(64'(result_dest), 64'(p[8:6]));
      check(64'(result_unit), 64'(u));
   endtask
   // A result pulse stands one cycle while the data holds.
   task automatic idle(input logic [63:0] last);
      issue_valid = 1'b0;
      @(negedge clk_sys);
      check(64'(result_valid), 64'h0);
      check(result_data, last);
   endtask
   task automatic reset_check(input int n);
      sys_rst = 1'b1;
      repeat (n) @(negedge clk_sys);
      check(64'(result_valid), 64'h0);
      check(result_data, WORD_ZERO);
      check(64'(result_unit), 64'(UNIT_NONE));
      check(64'(result_dest), 64'h0);
      check(64'(issue_reject), 64'h0);
      check(64'(issue_ready), 64'h1);
      sys_rst = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // every count field in both directions.
   task automatic t_shift_counts;
      logic [23:0] n;
      for (int d = 0; d < 2; d++) begin
         for (int k = 0; k < 8; k++) begin
            n = (k == 0) ? COUNT_ONE : scalar_file_model_inst.a_file[k];
            run({d[0] ? OP_DSHR : OP_DSHL, 3'h1, 3'h2, k[2:0]},
                dshift(d[0], sreg(1), sreg(2), n), UNIT_SHIFT);
         end
      end
      idle(dshift(1'b1, sreg(1), sreg(2), 24'h000041));
   endtask
   // zero first source and rotation of one register.
   task automatic t_shift_special;
      logic [127:0] w;
      run({OP_DSHL, 3'h1, 3'h0, 3'h6}, sreg(1) << 3, UNIT_SHIFT);
      run({OP_DSHR, 3'h1, 3'h0, 3'h6}, sreg(1) >> 3, UNIT_SHIFT);
      w = {sreg(2), sreg(2)};
      run({OP_DSHL, 3'h2, 3'h2, 3'h6}, w[124:61], UNIT_SHIFT);
      run({OP_DSHR, 3'h2, 3'h2, 3'h6}, w[66:3], UNIT_SHIFT);
      run({OP_DSHL, 3'h2, 3'h2, 3'h2}, sreg(2), UNIT_SHIFT);
      run({OP_DSHR, 3'h2, 3'h2, 3'h0}, w[64:1], UNIT_SHIFT);
      idle(w[64:1]);
   endtask
   task automatic t_int;
      run({OP_IADD, 3'h3, 3'h1, 3'h2}, sreg(1) + sreg(2), UNIT_IADD);
      run({OP_IADD, 3'h3, 3'h6, 3'h7}, SIGN_ONLY, UNIT_IADD);
      run({OP_IADD, 3'h4, 3'h0, 3'h2}, sreg(2), UNIT_IADD);
      run({OP_IADD, 3'h5, 3'h0, 3'h0}, SIGN_ONLY, UNIT_IADD);
      run({OP_ISUB, 3'h6, 3'h1, 3'h2}, sreg(1) - sreg(2), UNIT_IADD);
      run({OP_ISUB, 3'h7, 3'h0, 3'h0}, SIGN_ONLY, UNIT_IADD);
      run({OP_ISUB, 3'h1, 3'h0, 3'h7}, 64'hFFFF_FFFF_FFFF_FFFF, UNIT_IADD);
      idle(64'hFFFF_FFFF_FFFF_FFFF);
   endtask
   task automatic t_fp;
      run({OP_FADD, 3'h1, 3'h3, 3'h3}, 64'h4002_8000_0000_0000, UNIT_FADD);
      run({OP_FADD, 3'h2, 3'h0, 3'h5}, 64'h3FF2_8000_0000_0000, UNIT_FADD);
      run({OP_FSUB, 3'h3, 3'h4, 3'h3}, 64'h4002_8000_0000_0000, UNIT_FADD);
      run({OP_FSUB, 3'h4, 3'h3, 3'h3}, WORD_ZERO, UNIT_FADD);
      run({OP_FSUB, 3'h5, 3'h0, 3'h3}, 64'hC001_8000_0000_0000, UNIT_FADD);
      idle(64'hC001_8000_0000_0000);
   endtask
   // opcodes outside the handled range are refused.
   task automatic t_reject;
      logic [6:0] ops [3] = '{7'h2D, 7'h34, 7'h00};
      foreach (ops[x]) begin
         issue_valid = 1'b1;
         issue_parcel = {ops[x], 9'h0A5};
         @(posedge clk_sys);
         @(negedge clk_sys);
         check(64'(issue_reject), 64'h1);
         check(64'(result_valid), 64'h0);
      end
      issue_valid = 1'b0;
      @(negedge clk_sys);
      check(64'(issue_reject), 64'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // The run needs about fifty cycles; the watchdog allows far more.
   initial begin
      repeat (3000) @(posedge clk_sys);
      fail_count++;
      final_report();
   end
   initial begin
      clk_sys = 1'b0;
      sys_rst = 1'b1;
      issue_valid = 1'b0;
      issue_parcel = 16'h0000;
      fail_count = 0;
      cmp_count = 0;
      reset_check(3);
      t_shift_counts();
      t_shift_special();
      reset_check(1);
      t_reject();
      t_int();
      t_fp();
      final_report();
   end
endmodule
`default_nettype wire
